// file: include/bom_cfg.svh
`ifndef BOM_CFG_SVH
`define BOM_CFG_SVH
// ---------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define OFF_CONFIG 8'h00
`define OFF_COMMAND 8'h04
`define OFF_STATUS 8'h08
`define OFF_RX_DL 8'h0C
`define OFF_TX_DL 8'h10
// ---------------------------------------------------------------
// configuration fields
// ---------------------------------------------------------------
`define CFG_HDLC_ACT 0
`define CFG_BOM_ACT 1
`define CFG_FIFO_EN 2
`define CFG_IN_TS 3
`define CFG_BRM 4
`define CFG_THR_LO 5
`define CFG_THR_HI 6
`define CFG_REG_TX 7
`define CFG_RESET 8'h00
`define CMD_RX_RESET 0
`define TX_DL_RESET 24'h000000
// ---------------------------------------------------------------
// stream constants
// ---------------------------------------------------------------
`define ONES_SYNC 4'h8
`define ONES_LAST 4'h7
`define SYNC_WINDOW_LAST 6'h1F
`define WINDOW_MAX 6'h3F
`define PACKET_BYTES 6'h0A
`define THR_32 6'h20
`define THR_16 6'h10
`define THR_4 6'h04
`define THR_2 6'h02
`define FLAG_PATTERN 8'h7E
`define STATUS_BYTE 8'h80
`define BIT_LAST 3'h7
`endif

// file: include/bom_pkg.sv
package bom_pkg;
    typedef enum logic {MODE_HDLC = 1'b0, MODE_BOM = 1'b1} rx_mode_t;
    typedef enum logic [1:0] {SAMP_HUNT = 2'b00, SAMP_CAPT = 2'b01} samp_t;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SYNC = 2'b01, TX_DATA = 2'b11} tx_state_t;
endpackage : bom_pkg

// file: hdl/sat_counter.sv
`timescale 1ns/10ps
module sat_counter #(
    parameter int W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic inc,
    input wire logic [W-1:0] max,
    output logic [W-1:0] count
);
    // clear wins over increment; holds at max
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (inc && count != max) begin
            count <= W'(count + 1'b1);
        end
    end
endmodule : sat_counter

// file: hdl/bom_datalink_receiver.sv
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "bom_cfg.svh"
module bom_datalink_receiver
    import bom_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_dl_strobe,
    input wire logic rx_dl_bit,
    input wire logic rx_mf_begin,
    input wire logic tx_dl_strobe,
    input wire logic tx_mf_begin,
    input wire logic [7:0] hdlc_rx_byte,
    input wire logic hdlc_rx_byte_valid,
    input wire logic hdlc_tx_bit,
    input wire logic [7:0] tx_fifo_data,
    input wire logic tx_fifo_valid,
    output logic tx_dl_bit,
    output logic tx_fifo_rd,
    output logic receive_fifo_wr,
    output logic [7:0] receive_fifo_data,
    output logic hdlc_rx_bit,
    output logic hdlc_rx_bit_valid,
    output logic sync_fail_irq,
    output logic message_end_irq,
    output logic pool_irq,
    output logic rx_mf_irq,
    output logic tx_mf_irq
);
    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    logic [7:0] common_config_one;
    logic [23:0] rx_datalink_regs;
    logic [23:0] tx_datalink_regs;
    logic receiver_reset_cmd;
    rx_mode_t mode;
    samp_t samp;
    wire logic wr_acc = psel & penable & pwrite & pready;
    wire logic hdlc_receiver_active = common_config_one[`CFG_HDLC_ACT];
    wire logic bitmsg_receiver_active = common_config_one[`CFG_BOM_ACT];
    wire logic datalink_fifo_enable = common_config_one[`CFG_FIFO_EN];
    wire logic in_timeslot_enable = common_config_one[`CFG_IN_TS];
    wire logic bitmsg_receive_mode = common_config_one[`CFG_BRM];
    wire logic datalink_reg_tx_enable = common_config_one[`CFG_REG_TX];
    wire logic route = datalink_fifo_enable & ~in_timeslot_enable;
    wire logic bitmsg_mode_indicator = (mode == MODE_BOM);
    logic [31:0] next_prdata;
    logic next_err;

    // zero wait: pready rises in the access phase of every transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    always_comb begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            `OFF_CONFIG: next_prdata = {24'h000000, common_config_one};
            `OFF_COMMAND: next_prdata = 32'h00000000;
            `OFF_STATUS: next_prdata = {30'h00000000, samp == SAMP_CAPT,
                bitmsg_mode_indicator};
            `OFF_RX_DL: next_prdata = {8'h00, rx_datalink_regs};
            `OFF_TX_DL: next_prdata = {8'h00, tx_datalink_regs};
            default: next_err = 1'b1;
        endcase
    end

    // read data is captured at the end of the setup phase, on the same edge that raises pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= next_err;
        end
    end

    // mode bits may be rewritten at any time, no reset needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            common_config_one <= `CFG_RESET;
            tx_datalink_regs <= `TX_DL_RESET;
        end else if (wr_acc && paddr == `OFF_CONFIG) begin
            common_config_one <= pwdata[7:0];
        end else if (wr_acc && paddr == `OFF_TX_DL) begin
            tx_datalink_regs <= pwdata[23:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receiver_reset_cmd <= 1'b0;
        end else begin
            receiver_reset_cmd <= wr_acc && paddr == `OFF_COMMAND && pwdata[`CMD_RX_RESET];
        end
    end

    // ---------------------------------------------------------------
    // receive stream watch
    // ---------------------------------------------------------------
    logic [7:0] hist;
    logic [3:0] ones;
    logic [5:0] win;
    logic [5:0] stored;
    logic [5:0] limit;
    logic [2:0] cidx;
    logic [7:0] cand;
    logic status_pend;
    wire logic [7:0] next_hist = {hist[6:0], rx_dl_bit};
    wire logic flag_now = rx_dl_strobe && next_hist == `FLAG_PATTERN;
    wire logic run_hit = rx_dl_strobe && rx_dl_bit && ones == `ONES_LAST;
    wire logic enter_bom = mode == MODE_HDLC && bitmsg_receiver_active && run_hit
        && !receiver_reset_cmd;
    wire logic leave_bom = mode == MODE_BOM && !receiver_reset_cmd
        && (flag_now || !bitmsg_receiver_active);
    wire logic bom_stay = (mode == MODE_BOM && !leave_bom && !receiver_reset_cmd)
        || enter_bom;
    wire logic win_done = rx_dl_strobe && mode == MODE_BOM && win == `SYNC_WINDOW_LAST
        && !run_hit;
    wire logic byte_done = bom_stay && rx_dl_strobe && samp == SAMP_CAPT
        && cidx == `BIT_LAST;
    wire logic [7:0] full_byte = {rx_dl_bit, cand[6:0]};
    wire logic store = byte_done && route && !cand[0] && !rx_dl_bit;
    wire logic count_hit = store && 6'(stored + 1'b1) >= limit;
    wire logic close_msg = leave_bom && route
        && (bitmsg_receive_mode || !bitmsg_receiver_active);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist <= 8'h00;
        end else if (rx_dl_strobe) begin
            hist <= next_hist;
        end
    end

    sat_counter #(.W(4)) ones_run (
        .pclk(pclk),
        .presetn(presetn),
        .clear(receiver_reset_cmd | (rx_dl_strobe & ~rx_dl_bit)),
        .inc(rx_dl_strobe & rx_dl_bit),
        .max(`ONES_SYNC),
        .count(ones)
    );

    // the window restarts at every sync run so a healthy stream never trips it
    sat_counter #(.W(6)) sync_window (
        .pclk(pclk),
        .presetn(presetn),
        .clear(receiver_reset_cmd | ~bom_stay | run_hit | win_done),
        .inc(rx_dl_strobe),
        .max(`WINDOW_MAX),
        .count(win)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_HDLC;
        end else if (receiver_reset_cmd) begin
            mode <= MODE_HDLC;
        end else if (enter_bom) begin
            mode <= MODE_BOM;
        end else if (leave_bom) begin
            mode <= MODE_HDLC;
        end
    end

    // ---------------------------------------------------------------
    // byte sampling
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp <= SAMP_HUNT;
            cidx <= 3'h0;
            cand <= 8'h00;
        end else if (!bom_stay) begin
            samp <= SAMP_HUNT;
            cidx <= 3'h0;
        end else if (rx_dl_strobe) begin
            case (samp)
                SAMP_HUNT: begin
                    if (run_hit || win_done) begin
                        samp <= SAMP_CAPT;
                        cidx <= 3'h0;
                    end
                end
                SAMP_CAPT: begin
                    cand[cidx] <= rx_dl_bit;
                    cidx <= 3'(cidx + 1'b1);
                    if (cidx == `BIT_LAST) begin
                        samp <= SAMP_HUNT;
                    end
                end
                default: begin
                    samp <= SAMP_HUNT;
                end
            endcase
        end
    end

    always_comb begin
        case (common_config_one[`CFG_THR_HI:`CFG_THR_LO])
            2'b00: limit = `THR_32;
            2'b01: limit = `THR_16;
            2'b10: limit = `THR_4;
            default: limit = `THR_2;
        endcase
        if (!bitmsg_receive_mode) begin
            limit = `PACKET_BYTES;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stored <= 6'h00;
        end else if (!bom_stay || count_hit) begin
            stored <= 6'h00;
        end else if (store) begin
            stored <= 6'(stored + 1'b1);
        end
    end

    // a new closing event wins over the write that drains the last one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_pend <= 1'b0;
        end else if ((count_hit && !bitmsg_receive_mode) || close_msg) begin
            status_pend <= 1'b1;
        end else if (!store || !route) begin
            status_pend <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_fifo_wr <= 1'b0;
            receive_fifo_data <= 8'h00;
        end else if (!datalink_fifo_enable) begin
            receive_fifo_wr <= hdlc_rx_byte_valid;
            receive_fifo_data <= hdlc_rx_byte;
        end else if (store) begin
            receive_fifo_wr <= 1'b1;
            receive_fifo_data <= full_byte;
        end else if (status_pend && route) begin
            receive_fifo_wr <= 1'b1;
            receive_fifo_data <= `STATUS_BYTE;
        end else begin
            receive_fifo_wr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            message_end_irq <= 1'b0;
            pool_irq <= 1'b0;
            sync_fail_irq <= 1'b0;
        end else begin
            message_end_irq <= datalink_fifo_enable && route && status_pend && !store;
            pool_irq <= count_hit && bitmsg_receive_mode;
            sync_fail_irq <= win_done;
        end
    end

    // hdlc receiver sees every bit, so a frame is taken straight out of bom mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdlc_rx_bit <= 1'b0;
            hdlc_rx_bit_valid <= 1'b0;
        end else begin
            hdlc_rx_bit <= rx_dl_bit;
            hdlc_rx_bit_valid <= rx_dl_strobe && hdlc_receiver_active;
        end
    end

    // ---------------------------------------------------------------
    // multiframe registers
    // ---------------------------------------------------------------
    logic [23:0] rx_shift;
    logic [23:0] tx_shift;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_shift <= 24'h000000;
        end else if (rx_dl_strobe) begin
            rx_shift <= {rx_dl_bit, rx_shift[23:1]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_datalink_regs <= 24'h000000;
            rx_mf_irq <= 1'b0;
        end else begin
            rx_mf_irq <= rx_mf_begin;
            if (rx_mf_begin) begin
                rx_datalink_regs <= rx_shift;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_shift <= 24'h000000;
            tx_mf_irq <= 1'b0;
        end else begin
            tx_mf_irq <= tx_mf_begin && datalink_reg_tx_enable;
            if (tx_mf_begin && datalink_reg_tx_enable) begin
                tx_shift <= tx_datalink_regs;
            end else if (tx_dl_strobe) begin
                tx_shift <= {1'b1, tx_shift[23:1]};
            end
        end
    end

    // ---------------------------------------------------------------
    // transmit from fifo
    // ---------------------------------------------------------------
    tx_state_t tstate;
    logic [2:0] tcnt;
    logic [7:0] tbyte;
    wire logic fifo_path = route && !datalink_reg_tx_enable;
    wire logic tx_step = tx_dl_strobe && fifo_path;
    wire logic take = tstate == TX_DATA && tcnt == 3'h0 && tx_fifo_valid;
    logic fifo_bit;

    always_comb begin
        fifo_bit = 1'b1;
        if (tstate == TX_DATA) begin
            fifo_bit = (tcnt == 3'h0) ? (tx_fifo_data[0] | ~tx_fifo_valid) : tbyte[tcnt];
        end
    end

    // the preamble is the framer's job; only the sync byte is added here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tstate <= TX_IDLE;
            tcnt <= 3'h0;
            tbyte <= 8'h00;
        end else if (!fifo_path) begin
            tstate <= TX_IDLE;
            tcnt <= 3'h0;
        end else if (tx_step) begin
            case (tstate)
                TX_IDLE: begin
                    tcnt <= 3'h0;
                    if (tx_fifo_valid) begin
                        tstate <= TX_SYNC;
                    end
                end
                TX_SYNC: begin
                    tcnt <= 3'(tcnt + 1'b1);
                    if (tcnt == `BIT_LAST) begin
                        tstate <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tcnt == 3'h0 && !tx_fifo_valid) begin
                        tstate <= TX_IDLE;
                    end else begin
                        tcnt <= 3'(tcnt + 1'b1);
                        if (take) begin
                            tbyte <= tx_fifo_data;
                        end
                        if (tcnt == `BIT_LAST && !tx_fifo_valid) begin
                            tstate <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tstate <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_dl_bit <= 1'b1;
            tx_fifo_rd <= 1'b0;
        end else begin
            tx_fifo_rd <= tx_step && take;
            if (tx_dl_strobe) begin
                tx_dl_bit <= datalink_reg_tx_enable ? tx_shift[0] :
                    route ? fifo_bit : hdlc_tx_bit;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence packet_close_s;
        ##1 (receive_fifo_wr && receive_fifo_data != `STATUS_BYTE) ##1 (receive_fifo_wr && receive_fifo_data == `STATUS_BYTE);
    endsequence

    enter_bom_a: assert property (enter_bom |=> mode == MODE_BOM && samp == SAMP_CAPT)
        else $error("eight ones did not enter bom mode");
    flag_exit_a: assert property (mode == MODE_BOM && flag_now && !receiver_reset_cmd
        |=> mode == MODE_HDLC)
        else $error("flag did not return to hdlc mode");
    rx_reset_a: assert property (receiver_reset_cmd |=> mode == MODE_HDLC
        && samp == SAMP_HUNT)
        else $error("receiver reset left bom mode");
    store_byte_a: assert property (store && datalink_fifo_enable
        |=> receive_fifo_wr && receive_fifo_data == $past(full_byte))
        else $error("qualified byte not stored");
    discard_byte_a: assert property (byte_done && cand[0] && rx_dl_bit && datalink_fifo_enable
        |=> !receive_fifo_wr || receive_fifo_data == `STATUS_BYTE)
        else $error("ones framed byte was stored");
    sync_fail_a: assert property (win_done |=> sync_fail_irq ##0 samp == SAMP_CAPT
        || mode == MODE_HDLC)
        else $error("sync fail missing or sampling stopped");
    packet_end_a: assert property (count_hit && !bitmsg_receive_mode && datalink_fifo_enable
        |-> packet_close_s)
        else $error("status byte not appended after ten bytes");
    disable_close_a: assert property (mode == MODE_BOM && !bitmsg_receiver_active
        && !receiver_reset_cmd && route && !rx_dl_strobe
        |=> mode == MODE_HDLC ##1 (receive_fifo_wr && receive_fifo_data == `STATUS_BYTE && message_end_irq)
        ##1 !message_end_irq)
        else $error("disable did not close the message");
    pool_event_a: assert property (count_hit && bitmsg_receive_mode |=> pool_irq
        && stored == 6'h00)
        else $error("continuous pool event missing");
    tx_sync_a: assert property (tx_step && tstate == TX_IDLE && tx_fifo_valid
        |=> tstate == TX_SYNC && tcnt == 3'h0)
        else $error("sync byte not started before data");
endmodule : bom_datalink_receiver

// file: testbench/remote_term.sv
`timescale 1ns/10ps
// ----------------------------------------
// far-end terminal on the data link
// ----------------------------------------
module remote_term (
    input wire logic pclk,
    output logic rx_dl_strobe,
    output logic rx_dl_bit,
    output logic tx_dl_strobe
);
    logic [1:0] tick = 2'h0;
    initial begin
        rx_dl_strobe = 1'b0;
        rx_dl_bit = 1'b1;
        tx_dl_strobe = 1'b0;
    end
    // framer takes a transmit bit every fourth cycle
    always @(posedge pclk) begin
        tick <= tick + 2'h1;
        tx_dl_strobe <= (tick == 2'h0);
    end
    // strobes three cycles apart so a status byte finds a free slot
    task automatic send_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            rx_dl_strobe <= 1'b1;
            rx_dl_bit <= v[i];
            @(posedge pclk);
            rx_dl_strobe <= 1'b0;
            // line not held between bits
            rx_dl_bit <= ~v[i];
            @(posedge pclk);
        end
    endtask : send_byte
endmodule : remote_term

// file: testbench/bom_datalink_receiver_tb.sv
`timescale 1ns/10ps
`include "bom_cfg.svh"
module bom_datalink_receiver_tb
    import bom_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic rx_mf_begin = 1'b0;
    logic tx_mf_begin = 1'b0;
    // hdlc side idle except for the pass-through checks in t_regs: that controller is outside this bench
    logic [7:0] hdlc_rx_byte = 8'h00;
    logic hdlc_rx_byte_valid = 1'b0;
    logic hdlc_tx_bit = 1'b1;
    logic [7:0] tx_fifo_data = 8'h00;
    logic tx_fifo_valid = 1'b0;
    logic [31:0] prdata, rd;
    logic [7:0] receive_fifo_data;
    logic pready, pslverr, err, rx_dl_strobe, rx_dl_bit, tx_dl_strobe, tx_dl_bit;
    logic tx_fifo_rd, receive_fifo_wr, hdlc_rx_bit, hdlc_rx_bit_valid, sync_fail_irq;
    logic message_end_irq, pool_irq, rx_mf_irq, tx_mf_irq;
    logic [7:0] rq[$];
    int me_n = 0, pool_n = 0, sf_n = 0, rmf_n = 0, tmf_n = 0, hv_n = 0, m0, p0, s0;
    logic [23:0] hsh = 24'h000000;
    int miscompares = 0, n_compared = 0;
    always #50 pclk = ~pclk;
    bom_datalink_receiver dut_u (.*);
    remote_term far_u (.*);
    // ----------------------------------------
    // monitors
    // ----------------------------------------
    always @(posedge pclk) begin
        if (receive_fifo_wr === 1'b1) rq.push_back(receive_fifo_data);
        me_n += (message_end_irq === 1'b1);
        pool_n += (pool_irq === 1'b1);
        sf_n += (sync_fail_irq === 1'b1);
        rmf_n += (rx_mf_irq === 1'b1);
        tmf_n += (tx_mf_irq === 1'b1);
        hv_n += (hdlc_rx_bit_valid === 1'b1);
        if (hdlc_rx_bit_valid === 1'b1) hsh = {hdlc_rx_bit, hsh[23:1]};
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle
    task automatic unit(input logic [7:0] v);
        far_u.send_byte(8'hFF);
        far_u.send_byte(v);
    endtask : unit
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, `OFF_CONFIG, 32'h0);
        chk(rd, 32'(`CFG_RESET));
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `OFF_TX_DL, 32'hFFFFFFFF);
        apb(1'b0, `OFF_TX_DL, 32'h0);
        chk(rd, 32'h00FFFFFF);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(err), 32'h1);
        @(posedge pclk);
        hdlc_rx_byte <= 8'hA7;
        hdlc_rx_byte_valid <= 1'b1;
        hdlc_tx_bit <= 1'b0;
        @(posedge pclk);
        hdlc_rx_byte_valid <= 1'b0;
        idle(8);
        chk(32'(rq.size()), 32'h1);
        chk(32'(rq[0]), 32'hA7);
        chk({31'h0, tx_dl_bit}, 32'h0);
        hdlc_tx_bit <= 1'b1;
        $display("test regs done");
    endtask : t_regs
    task automatic t_packet();
        m0 = me_n;
        apb(1'b1, `OFF_CONFIG, 32'h07);
        rq.delete();
        for (int i = 1; i <= 10; i++) unit(8'(i << 1));
        idle(3);
        chk(32'(rq.size()), 32'h0B);
        chk(32'(rq[9]), 32'h14);
        chk(32'(rq[10]), 32'(`STATUS_BYTE));
        chk(32'(me_n - m0), 32'h1);
        $display("test packet done");
    endtask : t_packet
    task automatic t_store();
        rq.delete();
        unit(8'h5A);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        unit(8'h81);
        far_u.send_byte(`FLAG_PATTERN);
        idle(3);
        chk(32'(rq.size()), 32'h1);
        chk(32'(rq[0]), 32'h5A);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        $display("test store done");
    endtask : t_store
    task automatic t_cont();
        m0 = me_n;
        p0 = pool_n;
        apb(1'b1, `OFF_CONFIG, 32'h77);
        unit(8'h02);
        unit(8'h04);
        idle(3);
        chk(32'(pool_n - p0), 32'h1);
        far_u.send_byte(`FLAG_PATTERN);
        idle(3);
        chk(32'(rq[$]), 32'(`STATUS_BYTE));
        chk(32'(me_n - m0), 32'h1);
        unit(8'h02);
        apb(1'b1, `OFF_CONFIG, 32'h75);
        idle(4);
        chk(32'(rq[$]), 32'(`STATUS_BYTE));
        chk(32'(me_n - m0), 32'h2);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        $display("test continuous done");
    endtask : t_cont
    task automatic t_sync();
        s0 = sf_n;
        apb(1'b1, `OFF_CONFIG, 32'h07);
        far_u.send_byte(8'hFF);
        for (int i = 0; i < 5; i++) far_u.send_byte(8'h00);
        idle(2);
        chk(32'(sf_n > s0), 32'h1);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, `OFF_COMMAND, 32'h1);
        idle(2);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        $display("test sync done");
    endtask : t_sync
    task automatic t_mf();
        m0 = rmf_n;
        p0 = tmf_n;
        apb(1'b1, `OFF_CONFIG, 32'h81);
        apb(1'b1, `OFF_TX_DL, 32'h0000A5C3);
        s0 = hv_n;
        far_u.send_byte(8'h12);
        far_u.send_byte(8'h34);
        far_u.send_byte(8'h56);
        // load away from a transmit strobe so the first bit is not lost
        @(posedge pclk iff tx_dl_strobe === 1'b1);
        rx_mf_begin <= 1'b1;
        tx_mf_begin <= 1'b1;
        @(posedge pclk);
        rx_mf_begin <= 1'b0;
        tx_mf_begin <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk iff tx_dl_strobe === 1'b1);
            @(posedge pclk);
            chk({31'h0, tx_dl_bit}, 32'(8'hC3 >> i) & 32'h1);
        end
        chk(32'(rmf_n - m0), 32'h1);
        chk(32'(tmf_n - p0), 32'h1);
        chk(32'(hv_n - s0), 32'd24);
        chk({8'h00, hsh}, 32'h00563412);
        apb(1'b0, `OFF_RX_DL, 32'h0);
        chk(rd, 32'h00563412);
        $display("test multiframe done");
    endtask : t_mf
    task automatic t_txfifo();
        apb(1'b1, `OFF_CONFIG, 32'h07);
        @(posedge pclk iff tx_dl_strobe === 1'b1);
        tx_fifo_data <= 8'h3C;
        tx_fifo_valid <= 1'b1;
        // one idle one, eight sync ones, then the byte lsb first
        for (int i = 0; i < 17; i++) begin
            @(posedge pclk iff tx_dl_strobe === 1'b1);
            @(posedge pclk);
            if (i == 9) begin
                chk({31'h0, tx_fifo_rd}, 32'h1);
                tx_fifo_valid <= 1'b0;
            end
            chk({31'h0, tx_dl_bit}, (i < 9) ? 32'h1 : (32'(8'h3C >> (i - 9)) & 32'h1));
        end
        $display("test tx fifo done");
    endtask : t_txfifo
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_packet();
        t_store();
        t_cont();
        t_sync();
        t_mf();
        t_txfifo();
        results();
    end
    // run needs about 1200 cycles; allow far more
    initial begin
        #3000000;
        miscompares++;
        results();
    end
endmodule : bom_datalink_receiver_tb
